// ==== pct_pkg.sv ====
package pct_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PSC = 8'h04;
  localparam logic [7:0] OFS_ARR = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_CCMODE = 8'h18;
  localparam logic [7:0] OFS_DTIME = 8'h1c;
  localparam logic [7:0] OFS_CCR0 = 8'h20;
  localparam logic [7:0] OFS_EVGEN = 8'h30;
  // control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_DOWN = 1;
  localparam int CTRL_CENTER = 2;
  localparam int CTRL_ONEPULSE = 3;
  localparam int CTRL_DBGFRZ = 4;
  localparam int CTRL_ENC = 5;
  localparam int CTRL_SLVRST = 6;
  localparam int CTRL_DMAEN = 7;
  localparam int CTRL_W = 8;
  // status field positions
  localparam int ST_UPD = 0;
  localparam int ST_CC0 = 1;
  localparam int ST_HALL = 5;
  localparam int ST_TRIG = 6;
  localparam int ST_W = 7;
  // widths and reset values
  localparam int PSC_W = 16;
  localparam int DT_W = 8;
  localparam int MAX_CH = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [31:0] ARR_RST = 32'hffff_ffff;
  localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
  localparam logic [DT_W-1:0] DT_RST = 8'h00;
  // channel modes
  typedef enum logic [1:0] {PCT_CC_OFF, PCT_CC_CAP, PCT_CC_CMP, PCT_CC_PWM} pct_ccmode_t;
endpackage : pct_pkg

// ==== pct_tick_if.sv ====
`timescale 1ns/1ns
// prescaler link between counter core and divider
interface pct_tick_if;
  logic [pct_pkg::PSC_W-1:0] psc;
  logic upd;
  logic run;
  logic tick;
  modport timer (output psc, output upd, output run, input tick);
  modport presc (input psc, input upd, input run, output tick);
endinterface : pct_tick_if

// ==== pct_presc.sv ====
`timescale 1ns/1ns
module pct_presc (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to counter core
  pct_tick_if.presc tif
);
  import pct_pkg::*;
  logic [PSC_W-1:0] shadow_reg;
  logic [PSC_W-1:0] div_reg;

  // shadow loads only on update, divider restarts there
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shadow_reg <= PSC_RST;
      div_reg <= '0;
    end else begin
      if (tif.upd) shadow_reg <= tif.psc;
      if (tif.upd || tif.tick) div_reg <= '0;
      else if (tif.run) div_reg <= div_reg + 1'b1;
    end
  end

  // one tick every shadow+1 enabled cycles
  assign tif.tick = tif.run && (div_reg == shadow_reg);

  property p_tick_gap;
    @(posedge clock) disable iff (!rst_n)
    tif.tick && (shadow_reg != '0) && !tif.upd |=> !tif.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler ticked twice");
endmodule : pct_presc

// ==== pct_dtgen.sv ====
`timescale 1ns/1ns
module pct_dtgen #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // reference and dead time
  input wire logic ref_in,
  input wire logic [DW-1:0] dead,
  // complementary pair
  output logic out_p,
  output logic out_n
);
  logic prev_reg;
  logic [DW-1:0] cnt_reg;
  logic quiet;

  // both low until the dead count runs out
  assign quiet = (ref_in == prev_reg) && (cnt_reg == '0);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else begin
      prev_reg <= ref_in;
      if (ref_in != prev_reg) cnt_reg <= dead;
      else if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
      out_p <= ref_in && quiet;
      out_n <= !ref_in && quiet;
    end
  end

  property p_no_overlap;
    @(posedge clock) disable iff (!rst_n)
    $rose(out_p) |-> $past(!out_n, 1) && $past(!out_p, 1);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair overlap");
endmodule : pct_dtgen

// ==== pct_timer.sv ====
// Operation
// - counter 16 or 32 bits, auto-reload
// - prescaler divides by 1 to 65536
// - reduced: 16-bit counter, 16-bit prescaler
// - up to four capture or compare channels
// - edge or center aligned pwm
// - one-pulse mode stops after one period
// - complementary pairs with dead time
// - advanced: four complementary pairs on eight outputs
// - pwm duty from 0 to 100 percent
// - counter freezes during debug halt
// - trigger links between timers
// - own dma request per timer
// - full: quadrature encoder counting
// - full: one to four hall inputs
// - basic: no channels, dac trigger time base
// - reduced: one or two channels
`timescale 1ns/1ns
module pct_timer #(
  parameter int CW = 16,
  parameter int NUM_CH = 4,
  parameter bit FULL = 1'b1,
  parameter bit ADVANCED = 1'b0,
  parameter int HALL_N = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic [pct_pkg::MAX_CH-1:0] cap_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] hall_in,
  output logic [pct_pkg::MAX_CH-1:0] pwm_out,
  output logic [pct_pkg::MAX_CH-1:0] pwm_out_n,
  // system links
  input wire logic dbg_halt,
  input wire logic trig_in,
  output logic trig_out,
  output logic dac_trig,
  output logic dma_req,
  output logic irq
);
  import pct_pkg::*;

  pct_tick_if tif ();
  pct_presc u_presc (.clock(clock), .rst_n(rst_n), .tif(tif));

  logic [CTRL_W-1:0] ctrl_reg;
  logic [PSC_W-1:0] psc_reg;
  logic [CW-1:0] arr_reg;
  logic [CW-1:0] cnt_reg;
  logic [ST_W-1:0] st_reg;
  logic [ST_W-1:0] mask_reg;
  logic [7:0] ccmode_reg;
  logic [DT_W-1:0] dt_reg;
  logic [CW:0] ccr_reg [MAX_CH];
  logic [MAX_CH-1:0] oc_reg;
  logic dirc_reg;
  logic upd_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [9:0] s1_reg;
  logic [9:0] s2_reg;
  logic [9:0] s3_reg;

  // bus decode
  logic wr;
  logic [32:0] wext;
  assign wr = ap_valid_reg && ap_write_reg;
  assign wext = {1'b0, hwdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  wire wr_ctrl = wr && hit(ap_addr_reg, OFS_CTRL);
  wire wr_cnt = wr && hit(ap_addr_reg, OFS_CNT);
  wire wr_stat = wr && hit(ap_addr_reg, OFS_STAT);
  wire wr_ug = wr && hit(ap_addr_reg, OFS_EVGEN) && hwdata[0];

  // synchronised pins: caps, encoder, hall
  wire [MAX_CH-1:0] cap_rise = s2_reg[3:0] & ~s3_reg[3:0];
  wire enc_edge = FULL && (s2_reg[4] != s3_reg[4]);
  wire enc_down = s2_reg[4] == s2_reg[5];
  wire [3:0] hall_mask = 4'((1 << HALL_N) - 1);
  wire hall_chg = FULL && (((s2_reg[9:6] ^ s3_reg[9:6]) & hall_mask) != 4'h0);

  // counter controls
  wire en = ctrl_reg[CTRL_EN];
  wire center = FULL && ctrl_reg[CTRL_CENTER];
  wire enc_mode = FULL && ctrl_reg[CTRL_ENC];
  wire frozen = ctrl_reg[CTRL_DBGFRZ] && dbg_halt;
  wire slv_rst = ctrl_reg[CTRL_SLVRST] && trig_in;
  wire down = center ? dirc_reg : (enc_mode ? enc_down : FULL && ctrl_reg[CTRL_DOWN]);
  wire step = enc_mode ? enc_edge : tif.tick;
  wire cnt_en = en && !frozen && step;
  wire at_top = cnt_reg == arr_reg;
  wire at_bot = cnt_reg == '0;
  wire wrap = cnt_en && (down ? at_bot : at_top);
  wire upd_evt = wrap || wr_ug || slv_rst;

  // prescaler link
  assign tif.psc = psc_reg;
  assign tif.upd = upd_evt;
  assign tif.run = en && !frozen && !enc_mode;

  // next counter value
  logic [CW-1:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (wr_cnt) cnt_next = hwdata[CW-1:0];
    else if (wr_ug || slv_rst) cnt_next = '0;
    else if (cnt_en) begin
      if (center) cnt_next = down ? (at_bot ? cnt_reg + 1'b1 : cnt_reg - 1'b1)
                                  : (at_top ? cnt_reg - 1'b1 : cnt_reg + 1'b1);
      else if (down) cnt_next = at_bot ? arr_reg : cnt_reg - 1'b1;
      else cnt_next = at_top ? '0 : cnt_reg + 1'b1;
    end
  end

  // channel events and outputs
  logic [MAX_CH-1:0] cc_evt;
  logic [MAX_CH-1:0] oc_next;
  for (genvar i = 0; i < MAX_CH; i++) begin : g_ch
    pct_ccmode_t md;
    logic live;
    logic match;
    assign live = i < NUM_CH;
    assign md = pct_ccmode_t'(ccmode_reg[2*i +: 2]);
    assign match = cnt_en && (ccr_reg[i] == {1'b0, cnt_reg});
    assign cc_evt[i] = live && ((md == PCT_CC_CAP) ? cap_rise[i] : (md != PCT_CC_OFF) && match);
    assign oc_next[i] = !live ? 1'b0
                      : (md == PCT_CC_PWM) ? ({1'b0, cnt_reg} < ccr_reg[i])
                      : (md == PCT_CC_CMP) ? oc_reg[i] ^ match : 1'b0;
    // capture register or software value
    always_ff @(posedge clock) begin
      if (!rst_n) ccr_reg[i] <= '0;
      else if (wr && hit(ap_addr_reg, 8'(OFS_CCR0 + 4 * i))) ccr_reg[i] <= wext[CW:0];
      else if (live && md == PCT_CC_CAP && cap_rise[i]) ccr_reg[i] <= {1'b0, cnt_reg};
    end
    if (ADVANCED) begin : g_dt
      pct_dtgen #(.DW(DT_W)) u_dt (.clock(clock), .rst_n(rst_n), .ref_in(oc_reg[i]),
        .dead(dt_reg), .out_p(pwm_out[i]), .out_n(pwm_out_n[i]));
    end else begin : g_plain
      assign pwm_out[i] = oc_reg[i];
      assign pwm_out_n[i] = 1'b0;
    end
  end

  // sticky status, set wins over clear
  wire [ST_W-1:0] st_set = {trig_in, hall_chg, cc_evt, upd_evt};
  wire [ST_W-1:0] st_clr = wr_stat ? hwdata[ST_W-1:0] : '0;

  // pin synchronisers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {hall_in, enc_b, enc_a, cap_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ahb address phase capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= '0;
    end else if (hready) begin
      ap_valid_reg <= hsel && htrans[1] && (hsize == 3'b010);
      ap_write_reg <= hwrite;
      ap_addr_reg <= haddr[7:0];
    end
  end

  // configuration registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      psc_reg <= PSC_RST;
      arr_reg <= ARR_RST[CW-1:0];
      mask_reg <= '0;
      ccmode_reg <= '0;
      dt_reg <= DT_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= hwdata[CTRL_W-1:0];
      else if (wrap && ctrl_reg[CTRL_ONEPULSE]) ctrl_reg[CTRL_EN] <= 1'b0;
      if (wr && hit(ap_addr_reg, OFS_PSC)) psc_reg <= hwdata[PSC_W-1:0];
      if (wr && hit(ap_addr_reg, OFS_ARR)) arr_reg <= hwdata[CW-1:0];
      if (wr && hit(ap_addr_reg, OFS_MASK)) mask_reg <= hwdata[ST_W-1:0];
      if (wr && hit(ap_addr_reg, OFS_CCMODE)) ccmode_reg <= hwdata[7:0];
      if (wr && hit(ap_addr_reg, OFS_DTIME)) dt_reg <= hwdata[DT_W-1:0];
    end
  end

  // counter, direction, status, outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      dirc_reg <= 1'b0;
      st_reg <= '0;
      oc_reg <= '0;
      upd_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (!center || wr_ug) dirc_reg <= 1'b0;
      else if (cnt_en && (dirc_reg ? at_bot : at_top)) dirc_reg <= !dirc_reg;
      st_reg <= (st_reg & ~st_clr) | st_set;
      oc_reg <= oc_next;
      upd_reg <= upd_evt;
    end
  end

  // event outputs
  assign trig_out = upd_reg;
  assign dac_trig = upd_reg;
  assign dma_req = upd_reg && ctrl_reg[CTRL_DMAEN];
  assign irq = |(st_reg & mask_reg);

  // read mux
  logic [31:0] rd_ccr;
  assign rd_ccr = 32'(ccr_reg[ap_addr_reg[3:2]]);
  always_comb begin
    if (!ap_valid_reg || ap_write_reg) hrdata = 32'h0000_0000;
    else if (ap_addr_reg == OFS_CTRL) hrdata = 32'(ctrl_reg);
    else if (ap_addr_reg == OFS_PSC) hrdata = 32'(psc_reg);
    else if (ap_addr_reg == OFS_ARR) hrdata = 32'(arr_reg);
    else if (ap_addr_reg == OFS_CNT) hrdata = 32'(cnt_reg);
    else if (ap_addr_reg == OFS_STAT) hrdata = 32'(st_reg);
    else if (ap_addr_reg == OFS_MASK) hrdata = 32'(mask_reg);
    else if (ap_addr_reg == OFS_CCMODE) hrdata = 32'(ccmode_reg);
    else if (ap_addr_reg == OFS_DTIME) hrdata = 32'(dt_reg);
    else if (ap_addr_reg[7:4] == 4'h2 && ap_addr_reg[1:0] == 2'b00) hrdata = rd_ccr;
    else hrdata = 32'h0000_0000;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_upd_flag;
    upd_evt |=> st_reg[ST_UPD];
  endproperty
  a_upd_flag: assert property (p_upd_flag) else $error("update flag not set");

  property p_reload_up;
    wrap && !down && !center && !wr_cnt && !wr_ug && !slv_rst |=> cnt_reg == '0;
  endproperty
  a_reload_up: assert property (p_reload_up) else $error("no reload to zero");

  property p_reload_down;
    wrap && down && !center && !wr_cnt && !wr_ug && !slv_rst |=> cnt_reg == $past(arr_reg);
  endproperty
  a_reload_down: assert property (p_reload_down) else $error("no reload from arr");

  property p_freeze;
    frozen && !wr_cnt && !wr_ug && !slv_rst |=> $stable(cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved in debug halt");

  property p_up_only;
    !FULL |-> !down;
  endproperty
  a_up_only: assert property (p_up_only) else $error("reduced timer counted down");

  property p_onepulse;
    wrap && ctrl_reg[CTRL_ONEPULSE] && !wr_ctrl |=> !ctrl_reg[CTRL_EN] ##1 $stable(cnt_reg);
  endproperty
  a_onepulse: assert property (p_onepulse) else $error("one pulse did not stop");

  property p_duty_zero;
    NUM_CH > 0 && ccmode_reg[1:0] == 2'b11 && ccr_reg[0] == '0 |=> !oc_reg[0];
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty output high");

  property p_dma;
    dma_req |-> $past(upd_evt) && $past(ctrl_reg[CTRL_DMAEN]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma request without update");

  property p_cnt_write;
    wr_cnt |=> cnt_reg == $past(hwdata[CW-1:0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

  property p_center_turn;
    center && cnt_en && at_top && !dirc_reg && !wr_ug |=> dirc_reg;
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("no turn at top");

  property p_slave_reset;
    slv_rst && !wr_cnt |=> cnt_reg == '0 && trig_out;
  endproperty
  a_slave_reset: assert property (p_slave_reset) else $error("trigger did not restart");

  property p_trig_flag;
    trig_in |=> st_reg[ST_TRIG];
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger flag not set");

  property p_hall_flag;
    hall_chg |=> st_reg[ST_HALL];
  endproperty
  a_hall_flag: assert property (p_hall_flag) else $error("hall flag not set");

  property p_capture;
    NUM_CH > 0 && ccmode_reg[1:0] == 2'b01 && cap_rise[0] && !wr
      |=> ccr_reg[0] == {1'b0, $past(cnt_reg)};
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cmp_toggle;
    NUM_CH > 0 && ccmode_reg[1:0] == 2'b10 && cnt_en && ccr_reg[0] == {1'b0, cnt_reg}
      |=> oc_reg[0] != $past(oc_reg[0]);
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("compare did not toggle");

  property p_enc_up;
    enc_mode && en && !frozen && enc_edge && !down && !at_top && !wr_cnt && !wr_ug && !slv_rst
      |=> cnt_reg == $past(cnt_reg) + 1'b1;
  endproperty
  a_enc_up: assert property (p_enc_up) else $error("encoder step lost");

  c_update: cover property (wrap ##[1:20] wrap);
  c_center: cover property (center && wrap && dirc_reg);
  c_slave: cover property (slv_rst);
  c_capture: cover property (cc_evt[0] && ccmode_reg[1:0] == 2'b01);
  c_irq: cover property ($rose(irq));
endmodule : pct_timer

// ==== pct_far_model.sv ====
`timescale 1ns/1ns
module pct_far_model (
  // clock
  input wire logic clock,
  // sensor and capture lines toward the timer
  output logic enc_a,
  output logic enc_b,
  output logic [3:0] cap_in,
  output logic [3:0] hall_in
);
  // idle levels of the sensor lines
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    cap_in = 4'h0;
    hall_in = 4'h0;
  end
  // one line change, then time for the synchroniser
  task automatic step(input bit is_a, input logic lvl);
    @(posedge clock);
    if (is_a) enc_a <= lvl;
    else enc_b <= lvl;
    repeat (5) @(posedge clock);
  endtask : step
  // full quadrature cycles, forward lets a lead b
  task automatic quad(input int n, input bit rev);
    repeat (n) begin
      step(!rev, 1'b1);
      step(rev, 1'b1);
      step(!rev, 1'b0);
      step(rev, 1'b0);
    end
  endtask : quad
  // one rising edge on a capture pin
  task automatic cap(input int ch);
    @(posedge clock);
    cap_in[ch] <= 1'b1;
    repeat (6) @(posedge clock);
    cap_in[ch] <= 1'b0;
  endtask : cap
  // one hall sensor changes state
  task automatic hall_flip();
    @(posedge clock);
    hall_in[0] <= ~hall_in[0];
  endtask : hall_flip
endmodule : pct_far_model

// ==== tb_configurable_pwm_capture_timer.sv ====
`timescale 1ns/1ns
module tb_configurable_pwm_capture_timer;
  import pct_pkg::*;
  // duty table: compare values and expected {overlap, or, and, or_n, and_n}
  localparam logic [11:0] CCR_TAB = {4'h5, 4'ha, 4'h0};
  localparam logic [14:0] PW_EXP = {5'h0a, 5'h0c, 5'h03};
  logic clock, rst_n, hsel, hwrite, dbg_halt, trig_in, hreadyout, hresp;
  logic enc_a, enc_b, trig_out, dac_trig, dma_req, irq;
  logic [1:0] htrans;
  logic [2:0] hsize, sz;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [3:0] cap_in, hall_in, pwm_out, pwm_out_n;
  logic [4:0] r;
  logic [15:0] d;
  int errors, comparisons, cycles, n_dma, n_dac;

  // timer under test, bus ready looped back
  pct_timer #(.CW(16), .NUM_CH(4), .FULL(1'b1), .ADVANCED(1'b1), .HALL_N(3)) u_dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cap_in(cap_in),
    .enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in), .pwm_out(pwm_out),
    .pwm_out_n(pwm_out_n), .dbg_halt(dbg_halt), .trig_in(trig_in),
    .trig_out(trig_out), .dac_trig(dac_trig), .dma_req(dma_req), .irq(irq));

  // encoder, hall and capture sources
  pct_far_model u_far (.clock(clock), .enc_a(enc_a), .enc_b(enc_b), .cap_in(cap_in),
    .hall_in(hall_in));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // pulse counters and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_dma <= n_dma + int'(dma_req);
    n_dac <= n_dac + int'(dac_trig);
    if (cycles == 5000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] t;
    xfer(1'b1, a, wd, t);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rv);
    xfer(1'b0, a, 32'h0, rv);
  endtask : rd

  // count advance across ten cycles
  task automatic cdiff(output logic [15:0] diff);
    logic [31:0] a, b;
    rd(OFS_CNT, a);
    repeat (8) @(posedge clock);
    rd(OFS_CNT, b);
    diff = b[15:0] - a[15:0];
  endtask : cdiff

  // watch one channel pair over two periods
  task automatic pw(input int ch, output logic [4:0] res);
    res = 5'b00101;
    repeat (20) @(posedge clock);
    repeat (20) begin
      @(posedge clock);
      res[4] = res[4] | (pwm_out[ch] & pwm_out_n[ch]);
      res[3] = res[3] | pwm_out[ch];
      res[2] = res[2] & pwm_out[ch];
      res[1] = res[1] | pwm_out_n[ch];
      res[0] = res[0] & pwm_out_n[ch];
    end
  endtask : pw

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    {rst_n, hsel, hwrite, dbg_halt, trig_in} = 5'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    sz = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    {errors, comparisons, cycles, n_dma, n_dac} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // reset values and an unmapped place
    rd(OFS_ARR, v);
    chk(v & 32'hffff, 32'hffff);
    rd(OFS_PSC, v);
    chk(v, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, v);
    chk(v, 32'h0);
    // wrap makes flag, interrupt and dma pulses
    wr(OFS_ARR, 32'h4);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h81);
    repeat (20) @(posedge clock);
    chk(32'(irq), 32'h1);
    chk(32'(n_dma > 0 && n_dac > 0), 32'h1);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CNT, v);
    chk(32'(v <= 32'h4), 32'h1);
    wr(OFS_STAT, 32'h7f);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    // new divider waits for an update
    wr(OFS_ARR, 32'hffff);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_PSC, 32'h3);
    cdiff(d);
    chk(32'(d), 32'ha);
    wr(OFS_EVGEN, 32'h1);
    cdiff(d);
    chk(32'(d == 16'h2 || d == 16'h3), 32'h1);
    // debug halt freezes the count
    wr(OFS_CTRL, 32'h11);
    dbg_halt <= 1'b1;
    repeat (4) @(posedge clock);
    cdiff(d);
    chk(32'(d), 32'h0);
    dbg_halt <= 1'b0;
    repeat (4) @(posedge clock);
    cdiff(d);
    chk(32'(d != 16'h0), 32'h1);
    // downward count at divide by one
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PSC, 32'h0);
    wr(OFS_EVGEN, 32'h1);
    wr(OFS_CNT, 32'h8000);
    wr(OFS_CTRL, 32'h3);
    cdiff(d);
    chk(32'(d), 32'hfff6);
    // single pulse stops at the wrap
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ARR, 32'h5);
    wr(OFS_CNT, 32'h0);
    wr(OFS_CTRL, 32'h9);
    repeat (20) @(posedge clock);
    rd(OFS_CTRL, v);
    chk(v, 32'h8);
    // duty 0, 100 and 50 percent with dead time
    wr(OFS_CCMODE, 32'h3);
    wr(OFS_DTIME, 32'h2);
    wr(OFS_ARR, 32'h9);
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CCR0, {28'h0, CCR_TAB[i*4 +: 4]});
      pw(0, r);
      chk(32'(r), 32'(PW_EXP[i*5 +: 5]));
    end
    // capture, hall change and trigger link flags
    wr(OFS_CCMODE, 32'h7);
    wr(OFS_STAT, 32'h7f);
    u_far.cap(1);
    u_far.hall_flip();
    trig_in <= 1'b1;
    @(posedge clock);
    trig_in <= 1'b0;
    repeat (8) @(posedge clock);
    rd(OFS_STAT, v);
    chk(v & 32'h64, 32'h64);
    rd(8'h24, v);
    chk(32'(v <= 32'h9), 32'h1);
    // quadrature counting both ways
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ARR, 32'hffff);
    wr(OFS_CNT, 32'h64);
    wr(OFS_CTRL, 32'h21);
    u_far.quad(3, 1'b0);
    rd(OFS_CNT, v);
    chk(v, 32'h6a);
    u_far.quad(2, 1'b1);
    rd(OFS_CNT, v);
    chk(v, 32'h66);
    // center aligned count turns at both ends
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ARR, 32'h4);
    wr(OFS_CNT, 32'h0);
    wr(OFS_CTRL, 32'h5);
    cdiff(d);
    chk(32'(d), 32'h2);
    // compare mode toggles channel 2 once a period
    wr(OFS_CTRL, 32'h1);
    wr(8'h28, 32'h2);
    wr(OFS_CCMODE, 32'h20);
    pw(2, r);
    chk(32'(r), 32'h0a);
    // trigger input restarts the count and pulses the link
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CNT, 32'h3);
    wr(OFS_CTRL, 32'h41);
    trig_in <= 1'b1;
    rd(OFS_CNT, v);
    chk(32'(trig_out), 32'h1);
    trig_in <= 1'b0;
    chk(v, 32'h0);
    // a byte sized write leaves the register alone
    sz = 3'b000;
    wr(OFS_MASK, 32'h7f);
    sz = 3'b010;
    rd(OFS_MASK, v);
    chk(v, 32'h1);
    chk(32'(hresp), 32'h0);
    print_verdict();
  end
endmodule : tb_configurable_pwm_capture_timer
